// ---- hdl/press_option_switch_logic.sv ----
// option-switch policy logic of the press clutch/brake controller
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "press_option_cfg.svh"
module press_option_switch_logic (
  // clock and reset
  input  wire logic                        mclk,
  input  wire logic                        sys_rst,
  // switches and pins, asynchronous
  input  wire logic [7:0]                  first_option_bank,
  input  wire logic [7:0]                  second_option_bank,
  input  wire logic                        display_cam_enable_switch,
  input  wire logic                        muting_option_present,
  input  wire press_option_pkg::palm_in_t  palms,
  input  wire press_option_pkg::alarm_in_t alarms,
  // press state, same clock
  input  wire logic [8:0]                  crank_angle,
  input  wire logic                        press_running,
  input  wire logic                        inch_mode,
  input  wire logic                        stroke_interrupted,
  input  wire logic                        stroke_top,
  input  wire logic                        past_carry_up,
  input  wire logic                        multi_station,
  // register port
  input  wire logic [3:0]                  reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic [7:0]                       reg_rdata,
  // outputs
  output logic                             top_stop_req,
  output logic                             aux_out1,
  output logic [`AUX_DEVS-1:0]             aux_stop,
  output logic                             cam_set_enable,
  output logic                             stroke_permit,
  output logic                             irq
);
  //////////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers for every pin input
  localparam int SW = 16 + 2 + 3 + 6;
  logic [SW-1:0] raw;
  logic [SW-1:0] meta_q;
  logic [SW-1:0] sync_q;
  assign raw = {first_option_bank, second_option_bank, display_cam_enable_switch,
                muting_option_present, palms, alarms};
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= raw;
      sync_q <= meta_q;
    end
  end
  logic [7:0]                  bank1;
  logic [7:0]                  bank2;
  logic                        cam_sw;
  logic                        mute_opt;
  press_option_pkg::palm_in_t  palm_s;
  press_option_pkg::alarm_in_t alm;
  assign {bank1, bank2, cam_sw, mute_opt, palm_s, alm} = sync_q;
  // only positions one, two and six of bank two are decoded
  logic topstop_now;
  logic aux_mute_sw;
  logic conc_sw;
  assign topstop_now = bank1[`BANK1_TOPSTOP];
  assign aux_mute_sw = bank2[`BANK2_AUXMUTE];
  assign conc_sw     = bank2[`BANK2_CONC];
  //////////////////////////////////////////////////////////////////////////////
  // top-stop after stop faults
  logic stop_fault;
  logic fault_q;
  logic pend_next_q;
  logic top_stop_q;
  logic fault_rise;
  assign stop_fault = alm.fault_f | alm.fault_h;
  assign fault_rise = stop_fault & ~fault_q;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= stop_fault;
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pend_next_q <= 1'b0;
      top_stop_q  <= 1'b0;
    end else begin
      if (fault_rise && (topstop_now || crank_angle < `LATE_ANGLE)) begin
        top_stop_q <= 1'b1;
      end else if (fault_rise) begin
        pend_next_q <= 1'b1;
      end else if (stroke_top && pend_next_q) begin
        // late fault: let this stroke finish, stop at the end of the next
        pend_next_q <= 1'b0;
        top_stop_q  <= 1'b1;
      end else if (!stop_fault && !press_running && !pend_next_q) begin
        top_stop_q <= 1'b0;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // aux output 1 and aux e-stop relays
  logic intr_cond;
  logic aux1_drop;
  logic in_mute;
  logic curtain_stop;
  assign intr_cond = stroke_interrupted & ~inch_mode;
  assign aux1_drop = alm.fault_shown | alm.estop_open | (alm.curtain_break & press_running)
                   | (intr_cond & ~topstop_now);
  assign in_mute = aux_mute_sw & mute_opt & past_carry_up;
  assign curtain_stop = alm.curtain_break & ~in_mute;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      aux_out1 <= 1'b0;
      aux_stop <= '1;
      cam_set_enable <= 1'b0;
    end else begin
      aux_out1 <= ~aux1_drop;
      aux_stop <= {`AUX_DEVS{curtain_stop | alm.estop_open | alm.xcheck_open}};
      cam_set_enable <= bank2[`BANK2_CAM] | cam_sw;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // palm synchronous and concurrent windows
  press_option_pkg::palm_state_t st_q;
  logic [`CNT_W-1:0] sync_cnt_q;
  logic [`CNT_W-1:0] conc_cnt_q;
  logic a_pair;
  logic a_any;
  logic all_on;
  logic any_on;
  logic sync_ok_q;
  logic refused_ev;
  assign a_pair = palm_s.a_left & palm_s.a_right;
  assign a_any  = palm_s.a_left | palm_s.a_right;
  // secondary station module already enforced its own palm time
  assign all_on = a_pair & (palm_s.b_station | ~multi_station);
  assign any_on = a_any | palm_s.b_station;
  assign refused_ev = (st_q == press_option_pkg::PALM_TIMING)
                    && (conc_cnt_q == `CNT_W'(`CONC_CYCLES - 1)) && !all_on;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q       <= press_option_pkg::PALM_IDLE;
      sync_cnt_q <= '0;
      conc_cnt_q <= '0;
      sync_ok_q  <= 1'b0;
    end else begin
      unique case (st_q)
        press_option_pkg::PALM_IDLE: begin
          sync_cnt_q <= '0;
          conc_cnt_q <= '0;
          sync_ok_q  <= 1'b0;
          if (any_on) begin
            st_q <= press_option_pkg::PALM_TIMING;
          end
        end
        press_option_pkg::PALM_TIMING: begin
          conc_cnt_q <= conc_cnt_q + `CNT_W'(1);
          if (a_any && !sync_ok_q) begin
            sync_cnt_q <= sync_cnt_q + `CNT_W'(1);
          end
          if (a_pair) begin
            sync_ok_q <= 1'b1;
          end
          if (a_any && !a_pair && !sync_ok_q
              && sync_cnt_q == `CNT_W'(`SYNC_CYCLES - 1)) begin
            st_q <= press_option_pkg::PALM_LOCK;
          end else if (all_on && (a_pair || sync_ok_q)) begin
            st_q <= press_option_pkg::PALM_ARMED;
          end else if (refused_ev) begin
            st_q <= press_option_pkg::PALM_LOCK;
          end else if (!any_on) begin
            // a full release abandons the attempt, the next press starts fresh
            st_q <= press_option_pkg::PALM_IDLE;
          end
        end
        press_option_pkg::PALM_ARMED: begin
          if (!all_on) begin
            st_q <= press_option_pkg::PALM_LOCK;
          end
        end
        press_option_pkg::PALM_LOCK: begin
          if (!any_on) begin
            st_q <= press_option_pkg::PALM_IDLE;
          end
        end
      endcase
    end
  end
  // windows are the same with either concurrent setting; conc_sw is only reported
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stroke_permit <= 1'b0;
      top_stop_req  <= 1'b0;
    end else begin
      stroke_permit <= (st_q == press_option_pkg::PALM_ARMED) && !top_stop_q;
      top_stop_req  <= top_stop_q;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // interrupt status, mask and register read
  logic [`IRQ_W-1:0] ev;
  logic [`IRQ_W-1:0] stat_q;
  logic [`IRQ_W-1:0] mask_q;
  logic              ts_q;
  logic              as_q;
  logic              arm_q;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ts_q  <= 1'b0;
      as_q  <= 1'b0;
      arm_q <= 1'b0;
    end else begin
      ts_q  <= top_stop_q;
      as_q  <= |aux_stop;
      arm_q <= st_q == press_option_pkg::PALM_ARMED;
    end
  end
  always_comb begin
    ev = '0;
    ev[`IRQ_TOPSTOP] = top_stop_q & ~ts_q;
    ev[`IRQ_REFUSED] = refused_ev;
    ev[`IRQ_AUXSTOP] = (|aux_stop) & ~as_q;
    ev[`IRQ_ARMED]   = (st_q == press_option_pkg::PALM_ARMED) & ~arm_q;
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stat_q <= '0;
    end else if (reg_wr && reg_addr == `ADDR_STATUS) begin
      // a new event beats the clear
      stat_q <= (stat_q & ~reg_wdata[`IRQ_W-1:0]) | ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mask_q <= '0;
    end else if (reg_wr && reg_addr == `ADDR_MASK) begin
      mask_q <= reg_wdata[`IRQ_W-1:0];
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |((stat_q | ev) & mask_q);
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `ADDR_STATUS: reg_rdata <= {4'h0, stat_q};
        `ADDR_MASK:   reg_rdata <= {4'h0, mask_q};
        `ADDR_STATE:  reg_rdata <= {pend_next_q, top_stop_q, cam_set_enable, aux_out1,
                                    1'b0, conc_sw, st_q};
        default:      reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule : press_option_switch_logic

// ---- hdl/press_option_cfg.svh ----
// constants for the press option switch logic
`ifndef PRESS_OPTION_CFG_SVH
`define PRESS_OPTION_CFG_SVH
`define CLK_MHZ         125
`define SYNC_TIME_MS    500
`define CONC_TIME_MS    5000
`define SYNC_CYCLES     (`SYNC_TIME_MS * 1000 * `CLK_MHZ)
`define CONC_CYCLES     (`CONC_TIME_MS * 1000 * `CLK_MHZ)
`define CNT_W           30
`define LATE_ANGLE      9'd210
`define BANK1_TOPSTOP   7
`define BANK2_CAM       0
`define BANK2_AUXMUTE   1
`define BANK2_CONC      5
`define AUX_DEVS        3
`define IRQ_W           4
`define IRQ_TOPSTOP     0
`define IRQ_REFUSED     1
`define IRQ_AUXSTOP     2
`define IRQ_ARMED       3
`define ADDR_STATUS     4'h0
`define ADDR_MASK       4'h1
`define ADDR_STATE      4'h2
`endif

// ---- hdl/press_option_pkg.sv ----
// types for the press option switch logic
package press_option_pkg;
  typedef enum logic [1:0] {
    PALM_IDLE  = 2'b00,
    PALM_TIMING = 2'b01,
    PALM_ARMED = 2'b10,
    PALM_LOCK  = 2'b11
  } palm_state_t;
  typedef struct packed {
    logic a_left;
    logic a_right;
    logic b_station;
  } palm_in_t;
  typedef struct packed {
    logic fault_f;
    logic fault_h;
    logic fault_shown;
    logic estop_open;
    logic curtain_break;
    logic xcheck_open;
  } alarm_in_t;
endpackage : press_option_pkg

// ---- verification/press_option_assertions.sv ----
// concurrent checks on the ports of the press option switch logic
`timescale 1ns/1ps
module press_option_assertions (
  // clock and reset
  input wire logic                        mclk,
  input wire logic                        sys_rst,
  // switches, field and press state
  input wire logic [7:0]                  first_option_bank,
  input wire logic [7:0]                  second_option_bank,
  input wire logic                        display_cam_enable_switch,
  input wire logic                        muting_option_present,
  input wire press_option_pkg::palm_in_t  palms,
  input wire press_option_pkg::alarm_in_t alarms,
  input wire logic [8:0]                  crank_angle,
  input wire logic                        press_running,
  input wire logic                        inch_mode,
  input wire logic                        stroke_interrupted,
  input wire logic                        stroke_top,
  input wire logic                        past_carry_up,
  input wire logic                        multi_station,
  // outputs
  input wire logic                        top_stop_req,
  input wire logic                        aux_out1,
  input wire logic [2:0]                  aux_stop,
  input wire logic                        cam_set_enable,
  input wire logic                        stroke_permit
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  wire cam_src = second_option_bank[0] | display_cam_enable_switch;
  wire muted   = second_option_bank[1] & muting_option_present & past_carry_up;
  wire stop_src = alarms.estop_open | alarms.xcheck_open | (alarms.curtain_break & !muted);
  wire drop1   = alarms.fault_shown | alarms.estop_open | (alarms.curtain_break & press_running)
               | (stroke_interrupted & !first_option_bank[7] & !inch_mode);
  wire flt     = alarms.fault_f | alarms.fault_h;
  wire a_pair  = palms.a_left & palms.a_right;
  // a fault arriving past 210 degrees with the top-stop switch off
  sequence late_rise;
    $rose(flt) && !first_option_bank[7] && crank_angle > 9'h0D2 && !top_stop_req;
  endsequence
  cam_follow_a: assert property ($stable(cam_src) [*5] |-> cam_set_enable == cam_src)
    else $error("cam enable does not follow its switches");
  aux_stop_a: assert property ($stable(stop_src) [*5] |-> aux_stop == {3{stop_src}})
    else $error("aux stop does not match its causes");
  aux_one_a: assert property ($stable(drop1) [*5] |-> aux_out1 == !drop1)
    else $error("aux output 1 does not match its causes");
  top_now_a: assert property ($rose(flt) && (first_option_bank[7] || crank_angle < 9'h0D2)
    |-> ##[1:5] top_stop_req)
    else $error("top stop missing on the current stroke");
  late_hold_a: assert property (late_rise |-> !top_stop_req [*4])
    else $error("late fault stopped the current stroke");
  late_top_a: assert property (late_rise ##[6:40] stroke_top |-> ##[1:3] top_stop_req)
    else $error("late fault did not stop the next stroke");
  palm_drop_a: assert property (!a_pair [*5] |-> !stroke_permit)
    else $error("stroke permitted without the primary pair");
  b_need_a: assert property ((a_pair && multi_station && !palms.b_station) [*6]
    |-> !stroke_permit)
    else $error("stroke permitted without the secondary station");
endmodule : press_option_assertions
////////////////////////////////////////////////////////////////////////////////
bind press_option_switch_logic press_option_assertions chk (
  .mclk, .sys_rst, .first_option_bank, .second_option_bank, .display_cam_enable_switch,
  .muting_option_present, .palms, .alarms, .crank_angle, .press_running, .inch_mode,
  .stroke_interrupted, .stroke_top, .past_carry_up, .multi_station, .top_stop_req,
  .aux_out1, .aux_stop, .cam_set_enable, .stroke_permit
);

// ---- verification/press_field.sv ----
// operator stations, light curtain and e-stop strings around the press logic
`timescale 1ns/1ps
module press_field #(
  parameter int B_SYNC = 8
) (
  // clock
  input wire logic                  mclk,
  // field signals
  output press_option_pkg::palm_in_t  palms,
  output press_option_pkg::alarm_in_t alarms
);
  initial begin
    palms  = '0;
    alarms = '0;
  end
  task automatic press_a(input logic on);
    @(posedge mclk);
    palms.a_left  <= on;
    palms.a_right <= on;
  endtask : press_a
  // b station has its own two-hand module: a late second hand never shows
  task automatic press_b(input int gap);
    repeat (gap) @(posedge mclk);
    palms.b_station <= (gap <= B_SYNC);
  endtask : press_b
  task automatic release_all();
    @(posedge mclk);
    palms <= '0;
  endtask : release_all
  task automatic set_alarms(input press_option_pkg::alarm_in_t v);
    @(posedge mclk);
    alarms <= v;
  endtask : set_alarms
endmodule : press_field

// ---- verification/tb.sv ----
// self-checking bench for the press option switch logic
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((e) !== (s)) begin miscompares++; \
  $display("BAD %s expected %h seen %h", n, e, s); end end
module tb;
  typedef struct {
    string      name;
    int         sel;
    logic [7:0] exp;
  } note_t;
  logic       mclk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [7:0] first_option_bank = 8'h00;
  logic [7:0] second_option_bank = 8'h00;
  logic [8:0] crank_angle = 9'h000;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       display_cam_enable_switch = 1'b0, muting_option_present = 1'b0,
              press_running = 1'b0, inch_mode = 1'b0, stroke_interrupted = 1'b0,
              stroke_top = 1'b0, past_carry_up = 1'b0, multi_station = 1'b0,
              reg_wr = 1'b0, reg_rd = 1'b0, look_q = 1'b0;
  logic [7:0] reg_rdata;
  logic [2:0] aux_stop;
  logic       top_stop_req, aux_out1, cam_set_enable, stroke_permit, irq;
  int         tests_run = 0, miscompares = 0;
  note_t      notes[$];
  logic [7:0] seen [7];
  press_option_pkg::palm_in_t  palms;
  press_option_pkg::alarm_in_t alarms;
  always #4 mclk = ~mclk;
  always_comb seen = '{reg_rdata, {5'h00, aux_stop}, {7'h00, aux_out1},
                       {7'h00, top_stop_req}, {7'h00, cam_set_enable}, {7'h00, irq},
                       {7'h00, stroke_permit}};
  press_field field (.mclk, .palms, .alarms);
  press_option_switch_logic dut (
    .mclk, .sys_rst, .first_option_bank, .second_option_bank, .display_cam_enable_switch,
    .muting_option_present, .palms, .alarms, .crank_angle, .press_running, .inch_mode,
    .stroke_interrupted, .stroke_top, .past_carry_up, .multi_station, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .top_stop_req, .aux_out1, .aux_stop,
    .cam_set_enable, .stroke_permit, .irq
  );
  ////////////////////////////////////////////////////////////////////////////////
  // watcher: the oldest note is judged in the cycle it was asked for
  always @(posedge mclk) begin
    note_t n;
    if (look_q) begin
      n = notes.pop_front();
      `CHK(n.name, n.exp, seen[n.sel])
    end
  end
  task automatic look(input string n, input int s, input logic [7:0] e);
    notes.push_back('{n, s, e});
    look_q <= 1'b1;
    @(posedge mclk);
    look_q <= 1'b0;
    @(posedge mclk);
  endtask : look
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    look(n, 0, e);
  endtask : rd
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h8A2B03B3));
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rd(4'h1, 8'h00, "mask");
    rd(4'hF, 8'h00, "unmapped");
    // unused bank-two positions get random noise
    for (int i = 0; i < 3; i++) begin
      second_option_bank <= (i == 0) ? 8'h01 : 8'($urandom) & 8'hDC;
      display_cam_enable_switch <= (i == 1);
      repeat (3) @(posedge mclk);
      look("cam", 4, {7'h00, i < 2});
    end
    past_carry_up <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      second_option_bank[1] <= (i > 2);
      muting_option_present <= (i < 7);
      field.set_alarms(6'h04 >> (i % 3));
      repeat (3) @(posedge mclk);
      look("aux stop", 1, (i == 4) ? 8'h00 : 8'h07);
    end
    for (int i = 0; i < 4; i++) begin
      stroke_interrupted <= (i < 3);
      first_option_bank[7] <= (i % 2 == 1);
      inch_mode <= (i == 2);
      press_running <= (i == 3);
      field.set_alarms({4'h0, i == 3, 1'b0});
      repeat (3) @(posedge mclk);
      look("aux out1", 2, {7'h00, i == 1 || i == 2});
    end
    stroke_interrupted <= 1'b0;
    press_running <= 1'b0;
    wr(4'h1, 8'h01);
    for (int i = 0; i < 3; i++) begin
      first_option_bank[7] <= (i == 2);
      crank_angle <= (i == 0) ? 9'h064 : 9'h0FA;
      field.set_alarms({i == 1, i != 1, 4'h8});
      repeat (4) @(posedge mclk);
      look("top stop", 3, {7'h00, i != 1});
      if (i == 1) begin
        stroke_top <= 1'b1;
        @(posedge mclk);
        stroke_top <= 1'b0;
        repeat (2) @(posedge mclk);
        look("next top", 3, 8'h01);
      end
      look("irq", 5, 8'h01);
      field.set_alarms('0);
      repeat (3) @(posedge mclk);
      wr(4'h0, 8'h01);
      look("irq clear", 5, 8'h00);
    end
    wr(4'h1, 8'h00);
    field.set_alarms(6'h18);
    repeat (4) @(posedge mclk);
    look("masked irq", 5, 8'h00);
    field.set_alarms('0);
    for (int i = 0; i < 3; i++) begin
      wr(4'h0, 8'hFF);
      multi_station <= (i > 0);
      field.press_a(1'b1);
      if (i > 0) field.press_b(i == 1 ? 12 : 2);
      repeat (8) @(posedge mclk);
      rd(4'h0, (i == 1) ? 8'h00 : 8'h08, "armed");
      look("permit", 6, {7'h00, i != 1});
      field.release_all();
      repeat (8) @(posedge mclk);
    end
    wrap_up();
  end
endmodule : tb
